// >>> core/tsq_core.v
// Trigger sequence evaluator with resource terms, qualifiers, branching and global timers.
`include "tsq_regs.vh"
`default_nettype none
module tsq_core (
  input wire CLK,
  input wire RST,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WE,
  input wire RE,
  input wire [15:0] SMP_DATA,
  input wire SMP_VALID,
  output reg [31:0] RDATA,
  output reg TRIG
);
  localparam [1:0] LAST = 2'h3;
  // Shortest timer preset, held at the width of the preset registers.
  localparam [23:0] TMR_MIN = `TSQ_TMR_MIN_CYC;

  // Picks one of the sixteen term values by index.
  function sel_term;
    input [3:0] idx;
    input [15:0] vec;
    begin
      sel_term = vec[idx];
    end
  endfunction

  // True when the bus address selects word idx of a register group at base.
  function slot_hit;
    input [7:0] adr;
    input [7:0] base;
    input [7:0] step;
    input [7:0] idx;
    begin
      slot_hit = (adr == base + step * idx);
    end
  endfunction

  reg run_r;
  reg timing_r;
  reg [11:0] own_r;
  reg [11:0] inv_r;
  reg [17:0] edg_r [0:1];
  reg [31:0] rng_r [0:1];
  reg [23:0] tmr_r [0:1];
  reg [31:0] pat_r [0:9];
  reg [18:0] lcfg_r [0:3];
  reg [15:0] lcnt_r [0:3];
  reg [15:0] prv_r;
  reg [1:0] lvl_r;
  reg [15:0] cnt_r;
  reg done_r;
  wire [1:0] texp;
  wire [15:0] raw;
  wire [15:0] t;
  integer i;

  genvar g;
  generate
    for (g = 0; g < 10; g = g + 1)
    begin : g_pat
      assign raw[g] = (((SMP_DATA ^ pat_r[g][15:0]) & pat_r[g][31:16]) == 16'h0000)
        ^ inv_r[g];
    end
    for (g = 0; g < 2; g = g + 1)
    begin : g_rng
      // The compared field is the single data label; clock qualifiers never reach it.
      assign raw[10 + g] = ((SMP_DATA >= rng_r[g][15:0]) && (SMP_DATA <= rng_r[g][31:16]))
        ^ inv_r[10 + g];
    end
    for (g = 0; g < 2; g = g + 1)
    begin : g_edg
      wire [15:0] rise = ~prv_r & SMP_DATA & edg_r[g][15:0];
      wire [15:0] fall = prv_r & ~SMP_DATA & edg_r[g][15:0];
      wire [1:0] ty = edg_r[g][17:16];
      assign raw[12 + g] = ((ty == `TSQ_E_RISE) && (|rise)) ||
        ((ty == `TSQ_E_FALL) && (|fall)) ||
        ((ty == `TSQ_E_ANY) && (|(rise | fall)));
    end
  endgenerate

  assign raw[15:14] = texp;
  // Terms lent to the other machine read false here; edges stay local and timing-only.
  assign t = {raw[15:14], raw[13:12] & {2{timing_r}}, raw[11:0] & own_r};

  wire [18:0] cfg = lcfg_r[lvl_r];
  wire [15:0] lc = lcnt_r[lvl_r];
  wire [1:0] q = cfg[`TSQ_F_QUAL];
  wire p = sel_term(cfg[`TSQ_F_PRIM], t);
  wire alt_ok = (q == `TSQ_Q_NONE || q == `TSQ_Q_OCC) && (lvl_r != LAST);
  wire a = sel_term(cfg[`TSQ_F_ALT], t) & alt_ok;
  wire [15:0] inc = cnt_r + 16'h0001;

  reg [1:0] lvl_nxt;
  reg [15:0] cnt_nxt;
  reg done_nxt;
  reg trig_nxt;
  reg enter;
  reg hit;

  always @*
  begin
    lvl_nxt = lvl_r;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    trig_nxt = 1'b0;
    enter = 1'b0;
    hit = 1'b0;
    if (run_r && !done_r && SMP_VALID)
    begin
      case (q)
        `TSQ_Q_OCC:
        begin
          if (p)
          begin
            cnt_nxt = inc;
            hit = (inc >= lc);
          end
        end
        `TSQ_Q_GT:
        begin
          if (p)
          begin
            cnt_nxt = inc;
            hit = (inc >= lc);
          end
          else
            cnt_nxt = 16'h0000;
        end
        `TSQ_Q_LT:
        begin
          if (p)
            cnt_nxt = (cnt_r == 16'hffff) ? cnt_r : inc;
          else
          begin
            hit = (cnt_r != 16'h0000) && (cnt_r <= lc);
            cnt_nxt = 16'h0000;
          end
        end
        default: hit = p;
      endcase
      if (hit)
      begin
        cnt_nxt = 16'h0000;
        if (cfg[`TSQ_F_TRIG])
        begin
          trig_nxt = 1'b1;
          done_nxt = 1'b1;
        end
        else if (lvl_r != LAST)
        begin
          lvl_nxt = lvl_r + 2'h1;
          enter = 1'b1;
        end
      end
      else if (!p && a)
      begin
        cnt_nxt = 16'h0000;
        lvl_nxt = cfg[`TSQ_F_ALTLVL];
        enter = 1'b1;
      end
    end
  end

  wire [18:0] ncfg = lcfg_r[lvl_nxt];
  wire act_ok = enter && (lvl_nxt != 2'h0);

  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_tmr
      reg [23:0] c_r;
      reg on_r;
      reg exp_r;
      wire [2:0] act = !act_ok ? `TSQ_T_OFF :
        (g == 0) ? ncfg[`TSQ_F_ACT0] : ncfg[`TSQ_F_ACT1];
      wire [23:0] cinc = c_r + 24'h000001;
      assign texp[g] = exp_r;
      always @(posedge CLK)
      begin
        if (RST)
        begin
          c_r <= 24'h000000;
          on_r <= 1'b0;
          exp_r <= 1'b0;
        end
        else if (act == `TSQ_T_START)
        begin
          c_r <= 24'h000000;
          on_r <= 1'b1;
          exp_r <= 1'b0;
        end
        else if (act == `TSQ_T_STOP)
        begin
          c_r <= 24'h000000;
          on_r <= 1'b0;
          exp_r <= 1'b0;
        end
        else if (act == `TSQ_T_PAUSE)
          on_r <= 1'b0;
        else if (act == `TSQ_T_CONT)
          on_r <= 1'b1;
        else if (on_r)
        begin
          if (cinc >= tmr_r[g])
          begin
            c_r <= 24'h000000;
            on_r <= 1'b0;
            exp_r <= 1'b1;
          end
          else
            c_r <= cinc;
        end
      end
    end
  endgenerate

  wire wr_ctrl = WE && (ADDR == `TSQ_A_CTRL);
  wire clr = wr_ctrl && WDATA[`TSQ_C_CLEAR];

  always @(posedge CLK)
  begin
    if (RST)
    begin
      run_r <= 1'b0;
      timing_r <= 1'b0;
      own_r <= `TSQ_OWN_RST;
      inv_r <= 12'h000;
      prv_r <= 16'h0000;
      lvl_r <= 2'h0;
      cnt_r <= 16'h0000;
      done_r <= 1'b0;
      TRIG <= 1'b0;
      for (i = 0; i < 10; i = i + 1)
        pat_r[i] <= 32'h00000000;
      for (i = 0; i < 2; i = i + 1)
      begin
        edg_r[i] <= 18'h00000;
        rng_r[i] <= `TSQ_RNG_RST;
        tmr_r[i] <= TMR_MIN;
      end
      for (i = 0; i < 4; i = i + 1)
      begin
        lcfg_r[i] <= `TSQ_LVL_RST;
        lcnt_r[i] <= 16'h0000;
      end
    end
    else
    begin
      if (SMP_VALID)
        prv_r <= SMP_DATA;
      TRIG <= trig_nxt;
      if (wr_ctrl)
      begin
        // A control write restarts evaluation from the first level.
        run_r <= WDATA[`TSQ_C_RUN];
        timing_r <= WDATA[`TSQ_C_TIMING];
        lvl_r <= 2'h0;
        cnt_r <= 16'h0000;
        done_r <= 1'b0;
      end
      else
      begin
        lvl_r <= lvl_nxt;
        cnt_r <= cnt_nxt;
        done_r <= done_nxt;
      end
      if (clr)
      begin
        for (i = 0; i < 10; i = i + 1)
          pat_r[i] <= 32'h00000000;
        for (i = 0; i < 2; i = i + 1)
        begin
          edg_r[i] <= 18'h00000;
          rng_r[i] <= `TSQ_RNG_RST;
          tmr_r[i] <= TMR_MIN;
        end
      end
      else if (WE)
      begin
        if (ADDR == `TSQ_A_OWN)
          own_r <= WDATA[11:0];
        if (ADDR == `TSQ_A_INV)
          inv_r <= WDATA[11:0];
        for (i = 0; i < 2; i = i + 1)
        begin
          if (slot_hit(ADDR, `TSQ_A_EDG0, 8'h04, i[7:0]))
            edg_r[i] <= WDATA[17:0];
          if (slot_hit(ADDR, `TSQ_A_RNG0, 8'h04, i[7:0]))
            rng_r[i] <= WDATA;
          if (slot_hit(ADDR, `TSQ_A_TMR0, 8'h04, i[7:0]))
            tmr_r[i] <= (WDATA[23:0] < TMR_MIN) ? TMR_MIN : WDATA[23:0];
        end
        for (i = 0; i < 10; i = i + 1)
          if (slot_hit(ADDR, `TSQ_A_PAT0, 8'h04, i[7:0]))
            pat_r[i] <= WDATA;
        for (i = 0; i < 4; i = i + 1)
        begin
          if (slot_hit(ADDR, `TSQ_A_LVL0, 8'h08, i[7:0]))
            lcfg_r[i] <= WDATA[18:0];
          if (slot_hit(ADDR, `TSQ_A_LVL0 + 8'h04, 8'h08, i[7:0]))
            lcnt_r[i] <= WDATA[15:0];
        end
      end
    end
  end

  reg [31:0] rd;
  always @*
  begin
    rd = 32'h00000000;
    case (ADDR)
      `TSQ_A_CTRL: rd = {30'h0, timing_r, run_r};
      `TSQ_A_STAT: rd = {22'h0, texp, 3'h0, done_r, 2'h0, lvl_r};
      `TSQ_A_OWN: rd = {20'h0, own_r};
      `TSQ_A_INV: rd = {20'h0, inv_r};
      `TSQ_A_EDG0: rd = {14'h0, edg_r[0]};
      `TSQ_A_EDG0 + 8'h04: rd = {14'h0, edg_r[1]};
      `TSQ_A_RNG0: rd = rng_r[0];
      `TSQ_A_RNG0 + 8'h04: rd = rng_r[1];
      `TSQ_A_TMR0: rd = {8'h0, tmr_r[0]};
      `TSQ_A_TMR0 + 8'h04: rd = {8'h0, tmr_r[1]};
      default:
      begin
        for (i = 0; i < 10; i = i + 1)
          if (slot_hit(ADDR, `TSQ_A_PAT0, 8'h04, i[7:0]))
            rd = pat_r[i];
        for (i = 0; i < 4; i = i + 1)
        begin
          if (slot_hit(ADDR, `TSQ_A_LVL0, 8'h08, i[7:0]))
            rd = {13'h0, lcfg_r[i]};
          if (slot_hit(ADDR, `TSQ_A_LVL0 + 8'h04, 8'h08, i[7:0]))
            rd = {16'h0, lcnt_r[i]};
        end
      end
    endcase
  end

  always @(posedge CLK)
  begin
    if (RST)
      RDATA <= 32'h00000000;
    else if (RE)
      RDATA <= rd;
    else
      RDATA <= 32'h00000000;
  end
endmodule // tsq_core
`default_nettype wire

// >>> core/tsq_regs.vh
// Register map, field positions, reset values and timing counts of the trigger sequencer.
`ifndef TSQ_REGS_VH
`define TSQ_REGS_VH
`define TSQ_A_CTRL 8'h00
`define TSQ_A_STAT 8'h04
`define TSQ_A_OWN 8'h08
`define TSQ_A_EDG0 8'h0c
`define TSQ_A_RNG0 8'h14
`define TSQ_A_TMR0 8'h1c
`define TSQ_A_INV 8'h24
`define TSQ_A_PAT0 8'h40
`define TSQ_A_LVL0 8'h80
`define TSQ_C_RUN 0
`define TSQ_C_TIMING 1
`define TSQ_C_CLEAR 2
`define TSQ_F_PRIM 3:0
`define TSQ_F_ALT 7:4
`define TSQ_F_ALTLVL 9:8
`define TSQ_F_QUAL 11:10
`define TSQ_F_TRIG 12
`define TSQ_F_ACT0 15:13
`define TSQ_F_ACT1 18:16
`define TSQ_Q_NONE 2'h0
`define TSQ_Q_OCC 2'h1
`define TSQ_Q_GT 2'h2
`define TSQ_Q_LT 2'h3
`define TSQ_T_OFF 3'h0
`define TSQ_T_START 3'h1
`define TSQ_T_STOP 3'h2
`define TSQ_T_PAUSE 3'h3
`define TSQ_T_CONT 3'h4
`define TSQ_E_RISE 2'h1
`define TSQ_E_FALL 2'h2
`define TSQ_E_ANY 2'h3
`define TSQ_LVL_RST 19'h00000
`define TSQ_OWN_RST 12'hfff
`define TSQ_RNG_RST 32'hffff0000
`define TSQ_CLK_NS 40
`define TSQ_TMR_MIN_NS 400
`define TSQ_TMR_MIN_CYC ((`TSQ_TMR_MIN_NS + `TSQ_CLK_NS - 1) / `TSQ_CLK_NS)
`endif

// >>> sim/tsq_probe.sv
// Behavioural model of the probed target that drives one sampled data label.
`default_nettype none
module tsq_probe (
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] pat,
  output logic [15:0] data,
  output logic valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    data = 16'h0000;
    valid = 1'b0;
  end
  // Between samples the label flips every cycle, so the last word reappears on every second idle cycle.
  always @(posedge clk)
  begin
    valid <= go;
    data <= go ? pat : ~data;
  end
endmodule // tsq_probe
`default_nettype wire

// >>> sim/tsq_chk.sv
// Port checker for the trigger sequencer core.
`default_nettype none
`include "tsq_regs.vh"
module tsq_chk (
  input wire CLK,
  input wire RST,
  input wire [7:0] ADDR,
  input wire [31:0] WDATA,
  input wire WE,
  input wire RE,
  input wire SMP_VALID,
  input wire [31:0] RDATA,
  input wire TRIG
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence rd_of(a);
    RE && ADDR == a;
  endsequence
  sequence low_tmr_wr;
    WE && ADDR == `TSQ_A_TMR0 && WDATA[23:0] < `TSQ_TMR_MIN_CYC;
  endsequence
  chk_rdata_idle: assert property (!$past(RE) |-> RDATA == 32'h0)
    else $error("read data not idle");
  chk_trig_single: assert property (TRIG |=> !TRIG)
    else $error("trigger longer than one cycle");
  chk_trig_cause: assert property (TRIG |-> $past(SMP_VALID))
    else $error("trigger without a sample");
  chk_unmapped_zero: assert property (rd_of(8'hfc) |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_status_rsvd: assert property (rd_of(`TSQ_A_STAT) |=> (RDATA & 32'hfffffcec) == 32'h0)
    else $error("status reserved bits set");
  chk_done_shown: assert property (TRIG && RE && ADDR == `TSQ_A_STAT |=> RDATA[4])
    else $error("done flag missing after trigger");
  chk_ctrl_pulse: assert property (rd_of(`TSQ_A_CTRL) |=> RDATA[31:2] == 30'h0)
    else $error("clear bit stored");
  chk_tmr_clamp: assert property (low_tmr_wr ##1 rd_of(`TSQ_A_TMR0) |=> RDATA == `TSQ_TMR_MIN_CYC)
    else $error("timer preset not clamped");
endmodule // tsq_chk
`default_nettype wire

// >>> sim/tsq_core_bench.sv
// Self-checking bench for the trigger sequencer core.
`default_nettype none
`include "tsq_regs.vh"
module tsq_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] msk = 32'hffffffff;
  localparam logic [7:0] lv0 = `TSQ_A_LVL0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic go = 1'b0;
  logic [15:0] pat = 16'h0;
  wire [15:0] smp_data;
  wire smp_valid;
  wire [31:0] rdata;
  wire trig;
  int errors = 0;
  int cmp_count = 0;
  int trigs = 0;
  int cyc = 0;
  logic [15:0] td [6] = '{16'h1005, 16'h1000, 16'h2005, 16'h2006, 16'h0fff, 16'h0005};
  logic [1:0] tl [6] = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 2'h1};
  always #20 clk = ~clk;
  tsq_probe probe (.clk(clk), .go(go), .pat(pat), .data(smp_data), .valid(smp_valid));
  tsq_core uut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WE(we), .RE(re),
    .SMP_DATA(smp_data), .SMP_VALID(smp_valid), .RDATA(rdata), .TRIG(trig));
  task conclude;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task miss(input string m);
    errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    cmp_count++;
    if ((rdata & m) !== e)
      miss("read value");
  endtask
  task lv(input logic [1:0] l);
    rd(`TSQ_A_STAT, {30'h0, l}, 32'h3);
  endtask
  task run(input logic [31:0] c);
    wr(`TSQ_A_CTRL, c);
  endtask
  // Presents n consecutive samples, then waits until the last one is evaluated.
  task s(input logic [15:0] d, input int n);
    pat <= d;
    go <= 1'b1;
    repeat (n) @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (trig === 1'b1)
      trigs <= trigs + 1;
    if (cyc == 5000)
    begin
      miss("timeout");
      conclude;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    rd(`TSQ_A_OWN, `TSQ_OWN_RST, msk);
    rd(`TSQ_A_RNG0, `TSQ_RNG_RST, msk);
    rd(`TSQ_A_TMR0, `TSQ_TMR_MIN_CYC, msk);
    rd(lv0, 32'h0, msk);
    rd(8'hfc, 32'h0, msk);
    wr(`TSQ_A_TMR0, 32'h3);
    rd(`TSQ_A_TMR0, `TSQ_TMR_MIN_CYC, msk);
    wr(`TSQ_A_PAT0, 32'h000f0005);
    wr(`TSQ_A_RNG0, 32'h20051000);
    wr(lv0, 32'h2a0);
    for (int i = 0; i < 6; i++)
    begin
      run(32'h1);
      s(td[i], 1);
      lv(tl[i]);
    end
    wr(`TSQ_A_INV, 32'h400);
    run(32'h1);
    s(16'h0fff, 1);
    lv(2'h2);
    wr(`TSQ_A_INV, 32'h0);
    wr(lv0 + 8'h4, 32'h3);
    wr(lv0, 32'h6a0);
    run(32'h1);
    s(16'h5, 2);
    lv(2'h0);
    s(16'h5, 1);
    lv(2'h1);
    run(32'h1);
    s(16'h5, 2);
    s(16'h1000, 1);
    lv(2'h2);
    wr(lv0, 32'h4a0);
    run(32'h1);
    s(16'h5, 2);
    s(16'h1000, 1);
    s(16'h5, 2);
    lv(2'h0);
    s(16'h5, 1);
    lv(2'h1);
    wr(lv0, 32'haa0);
    run(32'h1);
    s(16'h5, 2);
    s(16'h1000, 1);
    lv(2'h0);
    s(16'h5, 3);
    lv(2'h1);
    wr(lv0 + 8'h4, 32'h2);
    wr(lv0, 32'hca0);
    run(32'h1);
    s(16'h5, 3);
    s(16'h0, 1);
    lv(2'h0);
    run(32'h1);
    s(16'h5, 2);
    s(16'h0, 1);
    lv(2'h1);
    wr(`TSQ_A_EDG0, 32'h10003);
    wr(lv0, 32'hc);
    run(32'h3);
    s(16'h0, 1);
    s(16'h2, 1);
    lv(2'h1);
    run(32'h1);
    s(16'h0, 1);
    s(16'h2, 1);
    lv(2'h0);
    wr(lv0, 32'h1000);
    run(32'h1);
    s(16'h5, 1);
    rd(`TSQ_A_STAT, 32'h10, 32'h10);
    s(16'h5, 1);
    cmp_count++;
    if (trigs !== 1)
      miss("trigger count");
    wr(lv0, 32'h2);
    wr(lv0 + 8'h8, 32'h200e);
    run(32'h1);
    s(16'h0, 1);
    rd(`TSQ_A_STAT, 32'h1, 32'h113);
    s(16'h0, 12);
    rd(`TSQ_A_STAT, 32'h102, 32'h113);
    wr(lv0 + 8'h10, 32'h4000);
    run(32'h1);
    s(16'h0, 12);
    rd(`TSQ_A_STAT, 32'h2, 32'h113);
    wr(lv0 + 8'h8, 32'h2000);
    wr(lv0 + 8'h10, 32'h6000);
    wr(lv0 + 8'h18, 32'h800e);
    run(32'h1);
    s(16'h0, 1);
    s(16'h5, 1);
    s(16'h0, 20);
    s(16'h5, 1);
    rd(`TSQ_A_STAT, 32'h3, 32'h113);
    s(16'h0, 12);
    rd(`TSQ_A_STAT, 32'h103, 32'h113);
    wr(lv0, 32'h2020);
    run(32'h1);
    s(16'h0, 1);
    rd(`TSQ_A_STAT, 32'h100, 32'h113);
    wr(`TSQ_A_OWN, 32'hffe);
    wr(lv0, 32'h0);
    run(32'h1);
    s(16'h5, 1);
    lv(2'h0);
    run(32'h4);
    rd(`TSQ_A_PAT0, 32'h0, msk);
    rd(`TSQ_A_RNG0, 32'hffff0000, msk);
    rd(`TSQ_A_CTRL, 32'h0, 32'h4);
    conclude;
  end
endmodule // tsq_core_bench
bind tsq_core tsq_chk chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WE(WE),
  .RE(RE), .SMP_VALID(SMP_VALID), .RDATA(RDATA), .TRIG(TRIG));
`default_nettype wire
